/* File: dv/hdseq_checker.sv */
`timescale 1ns/1ps
module hdseq_checker
	import hdseq_pkg::*;
#(
	parameter int TC_TICKS = 2,
	parameter int MS_TICKS = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [15:0] dac_left,
	input wire logic [15:0] dac_right,
	input wire logic [1:0] depop_charge_resistor,
	input wire logic slow_mode_left,
	input wire logic slow_mode_right,
	input wire logic left_headphone_driver_pwr,
	input wire logic right_headphone_driver_pwr,
	input wire logic [15:0] left_headphone_driver_data,
	input wire logic [15:0] right_headphone_driver_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [3:0] nsel_sh_q;
	// Shadow of the slow-charge code as the block accepts it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nsel_sh_q <= 4'h0;
		end else if (reg_wr && reg_addr == HDSEQ_ADDR_DEPOP_CFG && !left_headphone_driver_pwr
			&& !right_headphone_driver_pwr) begin
			nsel_sh_q <= reg_wdata[HDSEQ_NSEL_LSB +: 4];
		end
	end
	chk_left_blocked: assert property (slow_mode_left |-> left_headphone_driver_data == 16'h0000)
		else $error("left data during charge");
	chk_right_blocked: assert property (slow_mode_right |-> right_headphone_driver_data == 16'h0)
		else $error("right data during charge");
	chk_res_follows: assert property (reg_wr && reg_addr == HDSEQ_ADDR_DEPOP_CFG &&
		!left_headphone_driver_pwr && !right_headphone_driver_pwr
		|-> ##2 depop_charge_resistor == $past(reg_wdata[1:0], 2)) else $error("resistor code");
	chk_cfg_frozen: assert property ((left_headphone_driver_pwr || right_headphone_driver_pwr)
		&& $past(left_headphone_driver_pwr || right_headphone_driver_pwr)
		|-> $stable(depop_charge_resistor)) else $error("config moved while powered");
	chk_slow_powered: assert property (slow_mode_left |-> left_headphone_driver_pwr)
		else $error("slow mode unpowered");
	chk_slow_hold: assert property ($rose(slow_mode_right) && right_headphone_driver_pwr
		&& nsel_sh_q >= 4'h5 && TC_TICKS >= 2 |-> slow_mode_right[*8])
		else $error("charge too short");
	chk_zero_charge: assert property ($rose(slow_mode_left) && nsel_sh_q == 4'h0
		|=> !slow_mode_left) else $error("zero charge longer than one cycle");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("rdata without read");
	chk_flag_done: assert property ($past(reg_rd) && $past(reg_addr) == HDSEQ_ADDR_GAIN_FLAGS
		&& reg_rdata[7] |-> $past(left_headphone_driver_pwr) && !$past(slow_mode_left))
		else $error("flag before charge end");
	chk_left_route: assert property (left_headphone_driver_data != 16'h0
		|-> left_headphone_driver_data == $past(dac_left)) else $error("left data source");
endmodule : hdseq_checker
bind hdseq_top hdseq_checker #(.TC_TICKS(TC_TICKS), .MS_TICKS(MS_TICKS)) u_chk (.*);

/* File: dv/hdseq_load.sv */
`timescale 1ns/1ps
module hdseq_load (
	input wire logic clk,
	input wire logic pwr,
	input wire logic [15:0] data,
	output logic pop_q
);
	logic pwr_d;
	initial pop_q = 1'b0;
	initial pwr_d = 1'b0;
	// Latches audio reaching a single-ended load unpowered for a full cycle
	always @(posedge clk) begin
		pwr_d <= pwr;
		if (!pwr && !pwr_d && data != 16'h0000) begin
			pop_q <= 1'b1;
		end
	end
endmodule : hdseq_load

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import hdseq_pkg::*;
	localparam int TC = 2;
	logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [15:0] dac_left = 16'h1234, dac_right = 16'h5678, dl, dr;
	logic [1:0] res;
	logic sl, sr, pl, pr, popl, popr, ml, mr;
	logic [5:0] al, ar, gl, gr;
	int miscompares = 0, samples_checked = 0;
	always #4 clk = ~clk;
	hdseq_top #(.TC_TICKS(TC), .MS_TICKS(1)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.dac_left(dac_left), .dac_right(dac_right), .depop_charge_resistor(res),
		.slow_mode_left(sl), .slow_mode_right(sr), .left_headphone_driver_pwr(pl),
		.right_headphone_driver_pwr(pr), .left_headphone_driver_mute(ml),
		.right_headphone_driver_mute(mr), .left_atten(al), .right_atten(ar), .left_gain(gl),
		.right_gain(gr), .left_headphone_driver_data(dl), .right_headphone_driver_data(dr));
	hdseq_load u_ld (.clk(clk), .pwr(pl), .data(dl), .pop_q(popl));
	hdseq_load u_rd (.clk(clk), .pwr(pr), .data(dr), .pop_q(popr));
	// Counts one comparison, reports a mismatch
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) reg_wr <= 1'b0;
	endtask : wr
	// Read data taken in the one cycle it stands
	task automatic rd_raw(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd_raw
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_raw(a, d);
		chk(d, e);
	endtask : rd
	// Polls the flags until the expected value, bounded
	task automatic wait_flags(input logic [7:0] e);
		logic [7:0] f;
		int i;
		f = 8'h00;
		for (i = 0; i < 400 && f !== e; i++) rd_raw(HDSEQ_ADDR_GAIN_FLAGS, f);
		chk(f, e);
	endtask : wait_flags
	task automatic t_reset_regs;
		rd(HDSEQ_ADDR_DEPOP_CFG, HDSEQ_CFG_RESET);
		rd(HDSEQ_ADDR_GAIN_FLAGS, 8'h00);
		rd(HDSEQ_ADDR_DRV_CTRL, HDSEQ_CTRL_RESET);
		rd(8'h20, 8'h00);
		chk({ml, mr}, 2'b11);
	endtask : t_reset_regs
	// Charge of N = 9, no stepping, then stereo audio
	task automatic t_charge;
		int n;
		n = 0;
		wr(HDSEQ_ADDR_DEPOP_CFG, 8'h25);
		wr(HDSEQ_ADDR_ROUTE, 8'h01);
		wr(HDSEQ_ADDR_GAIN_L, 8'h10);
		wr(HDSEQ_ADDR_GAIN_R, 8'h3F);
		wr(HDSEQ_ADDR_DRV_CTRL, 8'h03);
		repeat (4) @(posedge clk);
		#1 chk(dl, 16'h0);
		while (sl === 1'b1 && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		chk(16'(n >= (5 * TC - 1) * HDSEQ_TICK_CYC - 4 && n <= 5 * TC * HDSEQ_TICK_CYC), 1);
		wait_flags(8'hC0);
		#1 chk(dl, dac_left);
		chk(dr, dac_right);
		chk(res, 2'h1);
		chk(gl, 6'h10);
		chk(gr, HDSEQ_GAIN_MAX);
		chk(al, 6'h10);
		chk(ar, HDSEQ_GAIN_MAX);
		wr(HDSEQ_ADDR_GAIN_L, 8'h05);
		#1 chk(al, 6'h05);
		wr(HDSEQ_ADDR_DEPOP_CFG, 8'hFF);
		rd(HDSEQ_ADDR_DEPOP_CFG, 8'h25);
	endtask : t_charge
	// 50 ms steps with 25k resistor: start attenuation masks gain, flags wait
	task automatic t_step;
		wr(HDSEQ_ADDR_DRV_CTRL, 8'h0C);
		rd(HDSEQ_ADDR_GAIN_FLAGS, 8'h00);
		wr(HDSEQ_ADDR_DEPOP_CFG, 8'h42);
		wr(HDSEQ_ADDR_DRV_CTRL, 8'h03);
		repeat (2000) @(posedge clk);
		#1 chk(al, 6'h00);
		rd(HDSEQ_ADDR_GAIN_FLAGS, 8'h00);
		chk(res, HDSEQ_RES_25K);
		repeat (50 * HDSEQ_TICK_CYC + 200) @(posedge clk);
		#1 chk(al, 6'h00);
		rd(HDSEQ_ADDR_GAIN_FLAGS, 8'h00);
	endtask : t_step
	// Line and mixer routed: extra left flags
	task automatic t_route_flags;
		wr(HDSEQ_ADDR_DRV_CTRL, 8'h0C);
		wr(HDSEQ_ADDR_DEPOP_CFG, 8'h00);
		wr(HDSEQ_ADDR_ROUTE, 8'h07);
		wr(HDSEQ_ADDR_DRV_CTRL, 8'h03);
		wait_flags(8'hCA);
		chk({popl, popr}, 2'b00);
	endtask : t_route_flags
	task automatic end_of_test;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset_regs();
		t_charge();
		t_step();
		t_route_flags();
		end_of_test();
	end
endmodule : tb_top

/* File: verilog/hdseq_chan.sv */
`timescale 1ns/1ps
module hdseq_chan
	import hdseq_pkg::*;
#(
	parameter int TC_TICKS = HDSEQ_TC_US,
	parameter int MS_TICKS = 1000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic pwr,
	input wire logic routed,
	input wire logic [3:0] nsel,
	input wire logic [1:0] step_sel,
	input wire logic [5:0] gain,
	output logic slow_mode,
	output logic path_en,
	output logic [5:0] atten,
	output logic done
);
	import hdseq_pkg::*;
	hdseq_state_t state_q;
	logic [31:0] cnt_q;
	logic [5:0] atten_q;
	logic done_q;

	// Slow-charge length in ticks, from a table in eighths of a time constant
	function automatic logic [31:0] charge_ticks(input logic [3:0] n);
		logic [31:0] e;
		e = 32'h0;
		unique case (n)
			4'h0: e = 32'h0;
			4'h1: e = 32'h4;
			4'h2: e = 32'h5;
			4'h3: e = 32'h6;
			4'h4: e = 32'h7;
			4'h5: e = 32'h8;
			4'hD: e = 32'h80;
			4'hE: e = 32'hC0;
			4'hF: e = 32'h100;
			default: e = 32'({28'h0, n} - 32'h4) * 32'h8; // R3
		endcase
		return 32'(e * 32'(TC_TICKS) / 32'h8);
	endfunction : charge_ticks

	// Step interval in ticks
	function automatic logic [31:0] step_ticks(input logic [1:0] s);
		logic [31:0] ms;
		ms = 32'h0;
		unique case (s)
			2'h0: ms = 32'h0;
			2'h1: ms = 32'(HDSEQ_STEP_50_MS);
			2'h2: ms = 32'(HDSEQ_STEP_100_MS);
			2'h3: ms = 32'(HDSEQ_STEP_200_MS);
		endcase
		return 32'(ms * 32'(MS_TICKS));
	endfunction : step_ticks

	// Power-up sequence, counters loaded at each phase start
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= HDSEQ_OFF;
			cnt_q <= 32'h0;
			atten_q <= HDSEQ_ATTEN_START;
			done_q <= 1'b0;
		end else if (!pwr) begin
			state_q <= HDSEQ_OFF;
			cnt_q <= 32'h0;
			atten_q <= HDSEQ_ATTEN_START;
			done_q <= 1'b0;
		end else begin
			unique case (state_q)
				HDSEQ_OFF: begin
					state_q <= HDSEQ_CHARGE;
					cnt_q <= charge_ticks(nsel); // R19
				end
				HDSEQ_CHARGE: begin
					if (cnt_q == 32'h0) begin // R5
						state_q <= HDSEQ_STEP;
						cnt_q <= step_ticks(step_sel); // R19
						if (step_sel == 2'h0) begin
							atten_q <= 6'h0; // R8
						end
					end else if (tick) begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				HDSEQ_STEP: begin
					if (!routed) begin
						cnt_q <= step_ticks(step_sel);
					end else if (atten_q == 6'h0) begin
						state_q <= HDSEQ_ON;
						done_q <= 1'b1; // R10
					end else if (cnt_q == 32'h0) begin
						atten_q <= atten_q - 6'h1; // R7
						cnt_q <= step_ticks(step_sel);
					end else if (tick) begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				HDSEQ_ON: begin
					atten_q <= 6'h0; // R9
				end
			endcase
		end
	end

	assign slow_mode = (state_q == HDSEQ_CHARGE); // R5
	assign path_en = (state_q == HDSEQ_STEP) || (state_q == HDSEQ_ON); // R6
	assign done = done_q;
	// Later gain changes pass straight; stepping only adds attenuation
	assign atten = (gain > atten_q) ? 6'(gain - atten_q) : 6'h0; // R9
endmodule : hdseq_chan

/* File: verilog/hdseq_pkg.sv */
package hdseq_pkg;
	// Register byte addresses on the plain register port
	localparam logic [7:0] HDSEQ_ADDR_DEPOP_CFG = 8'h14;
	localparam logic [7:0] HDSEQ_ADDR_GAIN_FLAGS = 8'h3F;
	localparam logic [7:0] HDSEQ_ADDR_DRV_CTRL = 8'h10;
	localparam logic [7:0] HDSEQ_ADDR_GAIN_L = 8'h11;
	localparam logic [7:0] HDSEQ_ADDR_GAIN_R = 8'h12;
	localparam logic [7:0] HDSEQ_ADDR_ROUTE = 8'h13;
	// Depop configuration fields
	localparam int HDSEQ_RES_LSB = 0;
	localparam int HDSEQ_NSEL_LSB = 2;
	localparam int HDSEQ_STEP_LSB = 6;
	localparam logic [1:0] HDSEQ_RES_25K = 2'h2;
	localparam logic [7:0] HDSEQ_CFG_RESET = 8'h00;
	// Driver control fields: power and mute per side
	localparam int HDSEQ_PWR_L = 0;
	localparam int HDSEQ_PWR_R = 1;
	localparam int HDSEQ_MUTE_L = 2;
	localparam int HDSEQ_MUTE_R = 3;
	localparam logic [7:0] HDSEQ_CTRL_RESET = 8'h0C;
	// Routing fields: dac, line input one, mixer amplifier
	localparam int HDSEQ_RT_DAC = 0;
	localparam int HDSEQ_RT_LINE = 1;
	localparam int HDSEQ_RT_MIX = 2;
	// Flag positions
	localparam int HDSEQ_FLG_L = 7;
	localparam int HDSEQ_FLG_R = 6;
	localparam int HDSEQ_FLG_LINE_L = 3;
	localparam int HDSEQ_FLG_MIX_L = 1;
	// Gain: code 0 is -6 dB, 1 dB per code up to +29 dB
	localparam logic [5:0] HDSEQ_GAIN_MAX = 6'h23;
	localparam logic [5:0] HDSEQ_ATTEN_START = 6'h3F;
	// Reference tick and step times
	localparam int HDSEQ_CLK_HZ = 125000000;
	localparam int HDSEQ_TICK_US = 1;
	localparam int HDSEQ_TICK_CYC = HDSEQ_CLK_HZ / 1000000 * HDSEQ_TICK_US;
	localparam int HDSEQ_STEP_50_MS = 50;
	localparam int HDSEQ_STEP_100_MS = 100;
	localparam int HDSEQ_STEP_200_MS = 200;
	localparam int HDSEQ_TC_US = 1000;
	typedef enum logic [1:0] {
		HDSEQ_OFF = 2'b00,
		HDSEQ_CHARGE = 2'b01,
		HDSEQ_STEP = 2'b10,
		HDSEQ_ON = 2'b11
	} hdseq_state_t;
endpackage : hdseq_pkg

/* File: verilog/hdseq_top.sv */
// How it works
// R1 - Left DAC to left driver, right to right
// R2 - Low two bits pick charging resistor
// R3 - Bits five to two pick slow-charge time
// R4 - Software avoids long codes with 25k resistor
// R5 - Drivers stay slow for whole charge time
// R6 - No signal path during slow charge
// R7 - First routing steps attenuation down gradually
// R8 - Bits seven six set step interval
// R9 - Stepping only at initial routing
// R10 - Flags bits seven six mark stepping done
// R11 - Host follows recommended power-up order
// R12 - Config written before power, then frozen
// R13 - Host checks flags before left power-down
// R14 - Mute changes only after steady state
// R15 - From -6 dB go -5 dB before mute
// R16 - Differential without capacitor may use zero
// R17 - Differential load should avoid driver mute
// R18 - Driver gain -6 to +29 dB, 1 dB
// R19 - Counters run on reference tick, loaded at start
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module hdseq_top
	import hdseq_pkg::*;
#(
	parameter int TC_TICKS = HDSEQ_TC_US,
	parameter int MS_TICKS = 1000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] dac_left,
	input wire logic [15:0] dac_right,
	output logic [1:0] depop_charge_resistor,
	output logic slow_mode_left,
	output logic slow_mode_right,
	output logic left_headphone_driver_pwr,
	output logic right_headphone_driver_pwr,
	output logic left_headphone_driver_mute,
	output logic right_headphone_driver_mute,
	output logic [5:0] left_atten,
	output logic [5:0] right_atten,
	output logic [5:0] left_gain,
	output logic [5:0] right_gain,
	output logic [15:0] left_headphone_driver_data,
	output logic [15:0] right_headphone_driver_data
);
	import hdseq_pkg::*;
	logic [7:0] cfg_q;
	logic [7:0] ctrl_q;
	logic [5:0] gain_l_q;
	logic [5:0] gain_r_q;
	logic [2:0] route_q;
	logic [7:0] rdata_q;
	logic [15:0] out_l_q;
	logic [15:0] out_r_q;
	logic [7:0] tick_cnt_q;
	logic tick_q;
	logic path_l;
	logic path_r;
	logic done_l;
	logic done_r;
	logic any_pwr;
	logic routed;
	logic [7:0] flags;

	assign any_pwr = ctrl_q[HDSEQ_PWR_L] | ctrl_q[HDSEQ_PWR_R];
	assign routed = |route_q;

	// Clamp gain code to the documented span
	function automatic logic [5:0] gain_clamp(input logic [7:0] v);
		return (v[5:0] > HDSEQ_GAIN_MAX || v[7:6] != 2'h0) ? HDSEQ_GAIN_MAX : v[5:0];
	endfunction : gain_clamp

	// Reference tick
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_q <= 8'h0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 8'(HDSEQ_TICK_CYC - 1)) begin
			tick_cnt_q <= 8'h0;
			tick_q <= 1'b1; // R19
		end else begin
			tick_cnt_q <= tick_cnt_q + 8'h1;
			tick_q <= 1'b0;
		end
	end

	// Depop configuration, frozen while a driver is powered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= HDSEQ_CFG_RESET;
		end else if (reg_wr && reg_addr == HDSEQ_ADDR_DEPOP_CFG && !any_pwr) begin
			cfg_q <= reg_wdata; // R2 R3 R8 R12
		end
	end

	// Driver control, gains and routing
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= HDSEQ_CTRL_RESET;
			gain_l_q <= 6'h0;
			gain_r_q <= 6'h0;
			route_q <= 3'h0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				HDSEQ_ADDR_DRV_CTRL: ctrl_q <= {4'h0, reg_wdata[3:0]};
				HDSEQ_ADDR_GAIN_L: gain_l_q <= gain_clamp(reg_wdata); // R18
				HDSEQ_ADDR_GAIN_R: gain_r_q <= gain_clamp(reg_wdata); // R18
				HDSEQ_ADDR_ROUTE: route_q <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// Completion flags; line and mixer bits follow the left driver
	always_comb begin
		flags = 8'h0;
		flags[HDSEQ_FLG_L] = done_l; // R10
		flags[HDSEQ_FLG_R] = done_r; // R10
		flags[HDSEQ_FLG_LINE_L] = done_l & route_q[HDSEQ_RT_LINE];
		flags[HDSEQ_FLG_MIX_L] = done_l & route_q[HDSEQ_RT_MIX];
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				HDSEQ_ADDR_DEPOP_CFG: rdata_q <= cfg_q;
				HDSEQ_ADDR_GAIN_FLAGS: rdata_q <= flags;
				HDSEQ_ADDR_DRV_CTRL: rdata_q <= ctrl_q;
				HDSEQ_ADDR_GAIN_L: rdata_q <= {2'h0, gain_l_q};
				HDSEQ_ADDR_GAIN_R: rdata_q <= {2'h0, gain_r_q};
				HDSEQ_ADDR_ROUTE: rdata_q <= {5'h0, route_q};
				default: rdata_q <= 8'h0;
			endcase
		end else begin
			rdata_q <= 8'h0;
		end
	end
	assign reg_rdata = rdata_q;

	hdseq_chan #(
		.TC_TICKS(TC_TICKS),
		.MS_TICKS(MS_TICKS)
	) u_left (
		.clk(clk),
		.rstn(rstn),
		.tick(tick_q),
		.pwr(ctrl_q[HDSEQ_PWR_L]),
		.routed(routed),
		.nsel(cfg_q[HDSEQ_NSEL_LSB +: 4]),
		.step_sel(cfg_q[HDSEQ_STEP_LSB +: 2]),
		.gain(gain_l_q),
		.slow_mode(slow_mode_left),
		.path_en(path_l),
		.atten(left_atten),
		.done(done_l)
	);

	hdseq_chan #(
		.TC_TICKS(TC_TICKS),
		.MS_TICKS(MS_TICKS)
	) u_right (
		.clk(clk),
		.rstn(rstn),
		.tick(tick_q),
		.pwr(ctrl_q[HDSEQ_PWR_R]),
		.routed(routed),
		.nsel(cfg_q[HDSEQ_NSEL_LSB +: 4]),
		.step_sel(cfg_q[HDSEQ_STEP_LSB +: 2]),
		.gain(gain_r_q),
		.slow_mode(slow_mode_right),
		.path_en(path_r),
		.atten(right_atten),
		.done(done_r)
	);

	// Stereo single-ended DAC path, blocked during charge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_l_q <= 16'h0;
			out_r_q <= 16'h0;
		end else begin
			out_l_q <= (path_l && ctrl_q[HDSEQ_PWR_L] && route_q[HDSEQ_RT_DAC]) ?
				dac_left : 16'h0; // R1 R6
			out_r_q <= (path_r && ctrl_q[HDSEQ_PWR_R] && route_q[HDSEQ_RT_DAC]) ?
				dac_right : 16'h0; // R1 R6
		end
	end

	assign left_headphone_driver_data = out_l_q;
	assign right_headphone_driver_data = out_r_q;
	assign depop_charge_resistor = cfg_q[HDSEQ_RES_LSB +: 2]; // R2
	assign left_headphone_driver_pwr = ctrl_q[HDSEQ_PWR_L];
	assign right_headphone_driver_pwr = ctrl_q[HDSEQ_PWR_R];
	assign left_headphone_driver_mute = ctrl_q[HDSEQ_MUTE_L];
	assign right_headphone_driver_mute = ctrl_q[HDSEQ_MUTE_R];
	assign left_gain = gain_l_q;
	assign right_gain = gain_r_q;
endmodule : hdseq_top
